// ---- hdl/ub_defs.svh ----
// Purpose: offsets, field positions, reset values and counts of the
//          auto-baud and wake-on-break block
// Assumes: 32-bit word registers on an AHB-Lite slave
// Notes:   byte addresses, one aligned word each
`ifndef UB_DEFS_SVH
`define UB_DEFS_SVH

`define UB_OFF_BAUD      32'h0000_0000
`define UB_OFF_MODE      32'h0000_0004
`define UB_OFF_DIV       32'h0000_0008
`define UB_OFF_RX        32'h0000_000c

`define UB_BIT_MEAS_EN   0
`define UB_BIT_WAKE_EN   1
`define UB_BIT_WIDE      3
`define UB_BIT_IDLE      6
`define UB_BIT_OVF       7
`define UB_BIT_HISPD     0
`define UB_BIT_SYNC      1
`define UB_BIT_RXFLAG    8

`define UB_RST_DIV       16'h0000
`define UB_CNT_START     16'h0001
`define UB_CNT_MAX       16'hffff
`define UB_LAST_RISE     3'h4

`define UB_DIV_SLOW      10'h200
`define UB_DIV_MID       10'h080
`define UB_DIV_FAST      10'h020

`endif

// ---- hdl/ub_pkg.sv ----
// Purpose: types of the auto-baud and wake-on-break block
// Assumes: constants live in ub_defs.svh
// Notes:   one packed state struct per module
package ub_pkg;

	typedef enum logic [2:0] {
		UB_IDLE,
		UB_WAKE_ARM,
		UB_WAKE_BREAK,
		UB_MEAS_START,
		UB_MEAS_FIRST,
		UB_MEAS_COUNT
	} ub_state_t;

	typedef enum logic [1:0] {
		UB_REG_BAUD,
		UB_REG_MODE,
		UB_REG_DIV,
		UB_REG_RX
	} ub_reg_t;

	typedef struct packed {
		ub_state_t   state;
		logic        autobaud_enable;
		logic        wake_on_break_enable;
		logic        wide_divisor_select;
		logic        high_speed_select;
		logic        sync_mode;
		logic        autobaud_overflow_flag;
		logic        receive_interrupt_flag;
		logic [15:0] baud_divisor;
		logic [2:0]  rises;
		logic        wr_pend;
		ub_reg_t     wr_sel;
		logic [31:0] rdata;
	} ub_top_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ub_sync_t;

	typedef struct packed {
		logic [9:0] cnt;
		logic       tick;
	} ub_pre_t;

endpackage

// ---- hdl/ub_sync.sv ----
// Purpose: two-flop synchroniser of the receive line with edge pulses
// Assumes: line idles high
// Notes:   s1 feeds only s2; edges come from s2 and s3
`timescale 1ns/1ps
module ub_sync (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic din,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	ub_pkg::ub_sync_t r;
	ub_pkg::ub_sync_t next_r;

	always_comb begin
		next_r    = r;
		next_r.s1 = din;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign level = r.s2;
	assign rise  = r.s2 & ~r.s3;
	assign fall  = ~r.s2 & r.s3;
endmodule

// ---- hdl/ub_prescale.sv ----
// Purpose: measuring clock strobe at mclk/512, /128 or /32
// Assumes: restart realigns the phase to the first rising edge
// Notes:   tick is a one-cycle registered strobe
`timescale 1ns/1ps
`include "ub_defs.svh"
module ub_prescale (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic       restart,
	input  wire logic [1:0] sel,
	output logic            tick
);
	ub_pkg::ub_pre_t r;
	ub_pkg::ub_pre_t next_r;

	// both selects low: slowest, one set: middle, both set: fastest
	function automatic logic [9:0] last_count(input logic [1:0] s);
		case (s)
			2'h0:    last_count = `UB_DIV_SLOW - 10'h001;
			2'h3:    last_count = `UB_DIV_FAST - 10'h001;
			default: last_count = `UB_DIV_MID - 10'h001;
		endcase
	endfunction

	always_comb begin
		next_r      = r;
		next_r.tick = 1'b0;
		if (restart) begin
			next_r.cnt = 10'h000;
		end else if (r.cnt == last_count(sel)) begin
			next_r.cnt  = 10'h000;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 10'h001;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			r <= '{cnt: 10'h000, tick: 1'b0};
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign tick = r.tick;
endmodule

// ---- hdl/ub_autobaud.sv ----
// Purpose: auto-baud measurement and wake-on-break for a serial receiver
// Assumes: AHB-Lite single word transfers; receiver logic on mclk
// Notes:   registers: baud control, mode, divisor, receive data
`timescale 1ns/1ps
`include "ub_defs.svh"
module ub_autobaud (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        receive_line_pin,
	input  wire logic        rx_busy,
	input  wire logic        rx_char_done,
	input  wire logic [7:0]  rx_data,
	output logic             rx_hold_idle,
	output logic             receive_interrupt_flag,
	output logic             autobaud_measure
);
	ub_pkg::ub_top_t r;
	ub_pkg::ub_top_t next_r;

	logic line_level;
	logic line_rise;
	logic line_fall;
	logic tick;
	logic restart;
	logic addr_ok;
	logic wr_baud;
	logic meas_on;
	logic wake_on;

	ub_sync u_sync (
		.mclk  (mclk),
		.rstn  (rstn),
		.ce    (ce),
		.din   (receive_line_pin),
		.level (line_level),
		.rise  (line_rise),
		.fall  (line_fall)
	);

	// measuring strobe phase starts with the first rise
	assign restart = (r.state == ub_pkg::UB_MEAS_FIRST) & line_rise;

	ub_prescale u_pre (
		.mclk    (mclk),
		.rstn    (rstn),
		.ce      (ce),
		.restart (restart),
		.sel     ({r.wide_divisor_select, r.high_speed_select}),
		.tick    (tick)
	);

	assign addr_ok = hsel & hready & htrans[1];
	assign wr_baud = r.wr_pend & (r.wr_sel == ub_pkg::UB_REG_BAUD);

	always_comb begin
		next_r = r;
		meas_on = 1'b0;
		wake_on = 1'b0;
		// data phase of a write
		if (r.wr_pend) begin
			next_r.wr_pend = 1'b0;
			if (r.wr_sel == ub_pkg::UB_REG_BAUD) begin
				next_r.autobaud_enable = hwdata[`UB_BIT_MEAS_EN];
				next_r.wake_on_break_enable =
					hwdata[`UB_BIT_WAKE_EN] & ~r.sync_mode;
				next_r.wide_divisor_select = hwdata[`UB_BIT_WIDE];
				// clear only once enable already reads zero
				if (!hwdata[`UB_BIT_OVF] && !r.autobaud_enable) begin
					next_r.autobaud_overflow_flag = 1'b0;
				end
			end else if (r.wr_sel == ub_pkg::UB_REG_MODE) begin
				next_r.high_speed_select = hwdata[`UB_BIT_HISPD];
				next_r.sync_mode = hwdata[`UB_BIT_SYNC];
				if (hwdata[`UB_BIT_SYNC]) begin
					next_r.wake_on_break_enable = 1'b0;
				end
			end else if (r.wr_sel == ub_pkg::UB_REG_DIV) begin
				// the counter owns the divisor while measuring
				if (r.state != ub_pkg::UB_MEAS_COUNT) begin
					next_r.baud_divisor = hwdata[15:0];
				end
			end
		end
		// address phase: decode, capture read data
		if (addr_ok) begin
			next_r.rdata = 32'h0000_0000;
			if (haddr == `UB_OFF_BAUD) begin
				next_r.wr_sel = ub_pkg::UB_REG_BAUD;
				next_r.rdata[`UB_BIT_MEAS_EN] = r.autobaud_enable;
				next_r.rdata[`UB_BIT_WAKE_EN] = r.wake_on_break_enable;
				next_r.rdata[`UB_BIT_WIDE] = r.wide_divisor_select;
				next_r.rdata[`UB_BIT_IDLE] = ~rx_busy;
				next_r.rdata[`UB_BIT_OVF] = r.autobaud_overflow_flag;
			end else if (haddr == `UB_OFF_MODE) begin
				next_r.wr_sel = ub_pkg::UB_REG_MODE;
				next_r.rdata[`UB_BIT_HISPD] = r.high_speed_select;
				next_r.rdata[`UB_BIT_SYNC] = r.sync_mode;
			end else if (haddr == `UB_OFF_DIV) begin
				next_r.wr_sel = ub_pkg::UB_REG_DIV;
				next_r.rdata[15:0] = r.baud_divisor;
			end else if (haddr == `UB_OFF_RX) begin
				next_r.wr_sel = ub_pkg::UB_REG_RX;
				next_r.rdata[7:0] = rx_data;
				next_r.rdata[`UB_BIT_RXFLAG] = r.receive_interrupt_flag;
				if (!hwrite) begin
					next_r.receive_interrupt_flag = 1'b0;
				end
			end
			// unmapped words read zero and ignore writes
			next_r.wr_pend = hwrite & (haddr == `UB_OFF_BAUD
				|| haddr == `UB_OFF_MODE || haddr == `UB_OFF_DIV);
		end
		// receiver's own characters raise the flag, set beats clear
		if (rx_char_done) begin
			next_r.receive_interrupt_flag = 1'b1;
		end
		case (r.state)
			ub_pkg::UB_IDLE: begin
				if (next_r.wake_on_break_enable) begin
					next_r.state = ub_pkg::UB_WAKE_ARM;
				end else if (next_r.autobaud_enable) begin
					next_r.state = ub_pkg::UB_MEAS_START;
				end
			end
			ub_pkg::UB_WAKE_ARM: begin
				wake_on = 1'b1;
				if (!next_r.wake_on_break_enable) begin
					next_r.state = ub_pkg::UB_IDLE;
				end else if (line_fall) begin
					// any falling edge counts, even a data start bit
					next_r.receive_interrupt_flag = 1'b1;
					next_r.state = ub_pkg::UB_WAKE_BREAK;
				end
			end
			ub_pkg::UB_WAKE_BREAK: begin
				wake_on = 1'b1;
				if (!next_r.wake_on_break_enable) begin
					next_r.state = ub_pkg::UB_IDLE;
				end else if (line_rise) begin
					next_r.wake_on_break_enable = 1'b0;
					if (next_r.autobaud_enable) begin
						next_r.state = ub_pkg::UB_MEAS_START;
					end else begin
						next_r.state = ub_pkg::UB_IDLE;
					end
				end
			end
			ub_pkg::UB_MEAS_START: begin
				meas_on = 1'b1;
				if (!next_r.autobaud_enable) begin
					next_r.state = ub_pkg::UB_IDLE;
				end else if (line_fall) begin
					next_r.state = ub_pkg::UB_MEAS_FIRST;
				end
			end
			ub_pkg::UB_MEAS_FIRST: begin
				meas_on = 1'b1;
				if (!next_r.autobaud_enable) begin
					next_r.state = ub_pkg::UB_IDLE;
				end else if (line_rise) begin
					next_r.baud_divisor = `UB_CNT_START;
					next_r.rises = 3'h1;
					next_r.state = ub_pkg::UB_MEAS_COUNT;
				end
			end
			ub_pkg::UB_MEAS_COUNT: begin
				meas_on = 1'b1;
				if (!next_r.autobaud_enable) begin
					next_r.state = ub_pkg::UB_IDLE;
				end else begin
					// one tick per 512, 128 or 32 mclk cycles, wraps on overflow
					if (tick) begin
						next_r.baud_divisor =
							r.baud_divisor + 16'h0001;
						if (r.baud_divisor == `UB_CNT_MAX) begin
							next_r.autobaud_overflow_flag = 1'b1;
						end
					end
					if (line_rise) begin
						if (r.rises == `UB_LAST_RISE) begin
							next_r.autobaud_enable = 1'b0;
							next_r.receive_interrupt_flag = 1'b1;
							next_r.state = ub_pkg::UB_IDLE;
						end else begin
							next_r.rises = r.rises + 3'h1;
						end
					end
				end
			end
			default: begin
				next_r.state = ub_pkg::UB_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			r <= '{state: ub_pkg::UB_IDLE,
			       baud_divisor: `UB_RST_DIV,
			       rises: 3'h0,
			       wr_sel: ub_pkg::UB_REG_BAUD,
			       rdata: 32'h0000_0000,
			       default: 1'b0};
		end else if (ce) begin
			r <= next_r;
		end
	end

	// a frozen block stalls the bus instead of losing a transfer
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;
	// receiver stays idle while measuring or armed for wake
	assign rx_hold_idle = meas_on | wake_on | r.autobaud_enable
		| r.wake_on_break_enable;
	assign receive_interrupt_flag = r.receive_interrupt_flag;
	assign autobaud_measure = (r.state == ub_pkg::UB_MEAS_COUNT);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	a_hold_while_enabled: assert property (
		r.autobaud_enable |-> rx_hold_idle)
		else $error("receiver not held idle while measuring");
	a_first_rise_loads: assert property (
		ce && r.state == ub_pkg::UB_MEAS_FIRST && line_rise
		&& r.autobaud_enable && !wr_baud
		|=> r.baud_divisor == 16'h0001 && autobaud_measure)
		else $error("counter did not start at one");
	a_tick_increments: assert property (
		ce && autobaud_measure && tick && !line_rise
		&& r.autobaud_enable && !wr_baud
		|=> r.baud_divisor == $past(r.baud_divisor) + 16'h0001)
		else $error("counter missed a measuring tick");
	a_fifth_rise_done: assert property (
		ce && autobaud_measure && line_rise && r.rises == 3'h4
		&& r.autobaud_enable && !wr_baud
		|=> !r.autobaud_enable && r.receive_interrupt_flag
		&& r.state == ub_pkg::UB_IDLE)
		else $error("fifth rise did not finish measurement");
	a_wrap_sets_ovf: assert property (
		ce && autobaud_measure && tick && r.baud_divisor == 16'hffff
		&& r.autobaud_enable && !wr_baud
		|=> r.autobaud_overflow_flag && r.baud_divisor == 16'h0000)
		else $error("overflow not flagged on wrap");
	a_ovf_held_enabled: assert property (
		r.autobaud_overflow_flag && r.autobaud_enable
		|=> r.autobaud_overflow_flag)
		else $error("overflow flag cleared while enabled");
	a_wake_fall_flag: assert property (
		ce && r.state == ub_pkg::UB_WAKE_ARM && line_fall
		&& r.wake_on_break_enable && !wr_baud
		|=> r.receive_interrupt_flag
		&& r.state == ub_pkg::UB_WAKE_BREAK)
		else $error("wake edge did not raise receive flag");
	a_break_end_clears: assert property (
		ce && r.state == ub_pkg::UB_WAKE_BREAK && line_rise && !wr_baud
		&& r.wake_on_break_enable
		|=> !r.wake_on_break_enable)
		else $error("break end did not clear wake enable");
	a_sync_no_wake: assert property (
		r.sync_mode |-> !r.wake_on_break_enable)
		else $error("wake armed in synchronous mode");

	c_measure_done: cover property (
		autobaud_measure ##1 !autobaud_measure && r.receive_interrupt_flag);
	c_wake_then_measure: cover property (
		r.state == ub_pkg::UB_WAKE_BREAK
		##1 r.state == ub_pkg::UB_MEAS_START);
	c_overflow: cover property (
		autobaud_measure && r.autobaud_overflow_flag);
endmodule

// ---- dv/ub_node_model.sv ----
// Purpose: remote serial node driving the receive line of the block
// Assumes: bit time is a whole number of mclk cycles
// Notes:   line rests high between frames, as a pulled-up serial line
`timescale 1ns/1ps
module ub_node_model #(
	parameter int BIT_CYC = 330
) (
	input  wire logic mclk,
	output logic      line
);
	initial line = 1'b1;

	// call right after a rising edge of mclk
	task automatic hold_bits(input logic v, input int n);
		line <= v;
		repeat (n * BIT_CYC) @(posedge mclk);
	endtask

	// start bit, eight data bits lsb first, one stop bit
	task automatic send_byte(input logic [7:0] b);
		int i;
		hold_bits(1'b0, 1);
		for (i = 0; i < 8; i++) begin
			hold_bits(b[i], 1);
		end
		hold_bits(1'b1, 1);
	endtask

	// all-zero wake character, then one idle bit
	task automatic send_break(input int nbits);
		hold_bits(1'b0, nbits);
		hold_bits(1'b1, 1);
	endtask
endmodule

// ---- dv/ub_autobaud_tb.sv ----
// Purpose: self-checking bench of the auto-baud and wake block
// Assumes: ce high outside the freeze test, so no wait states
// Notes:   overflow needs 2M cycles even at mclk/32, so it stays unreached
`timescale 1ns/1ps
`include "ub_defs.svh"
module ub_autobaud_tb;
	logic        mclk       = 1'b0;
	logic        rstn       = 1'b0;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic        ce         = 1'b1;
	logic [2:0]  hsize      = 3'h0;
	logic [7:0]  rx_data    = 8'h00;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic        line;
	logic        rx_busy    = 1'b0;
	logic        rx_done    = 1'b0;
	logic        rx_flag;
	logic        hold_idle;
	logic        measure;
	logic [31:0] rd;
	logic [15:0] div_exp [4] = '{16'd6, 16'd21, 16'd21, 16'd83};
	int          err_count  = 0;
	int          n_compared = 0;

	always #25 mclk = ~mclk;

	ub_autobaud ub_autobaud_inst (
		.mclk                   (mclk),
		.rstn                   (rstn),
		.ce                     (ce),
		.hsel                   (hsel),
		.haddr                  (haddr),
		.htrans                 (htrans),
		.hwrite                 (hwrite),
		.hsize                  (hsize),
		.hwdata                 (hwdata),
		.hready                 (hready),
		.hreadyout              (hready),
		.hresp                  (hresp),
		.hrdata                 (hrdata),
		.receive_line_pin       (line),
		.rx_busy                (rx_busy),
		.rx_char_done           (rx_done),
		.rx_data                (rx_data),
		.rx_hold_idle           (hold_idle),
		.receive_interrupt_flag (rx_flag),
		.autobaud_measure       (measure)
	);

	ub_node_model #(.BIT_CYC(330)) ub_node_model_inst (
		.mclk (mclk),
		.line (line)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// one single AHB transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'h0);
	endtask

	task automatic t_reset();
		rx_data <= 8'ha5;
		bus(1'b0, `UB_OFF_BAUD, 32'h0);
		chk(rd, 32'h40);
		bus(1'b0, `UB_OFF_DIV, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 32'h10, 32'hffff_ffff);
		bus(1'b0, 32'h10, 32'h0);
		chk(rd, 32'h0);
		rx_busy <= 1'b1;
		bus(1'b0, `UB_OFF_BAUD, 32'h0);
		chk(32'(rd[6]), 32'h0);
		rx_busy <= 1'b0;
		rx_done <= 1'b1;
		@(posedge mclk);
		rx_done <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(32'(rx_flag), 32'h1);
		bus(1'b0, `UB_OFF_RX, 32'h0);
		chk(32'(rd[8:0]), 32'h1a5);
		chk(32'(rx_flag), 32'h0);
		$display("reset and registers done");
	endtask

	// ce low stalls the bus and holds the flag against a receive event
	task automatic t_freeze();
		ce      <= 1'b0;
		rx_done <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(32'({hready, rx_flag}), 32'h0);
		rx_done <= 1'b0;
		ce      <= 1'b1;
		@(posedge mclk);
		chk(32'({hready, rx_flag}), 32'h2);
		$display("clock enable done");
	endtask

	// 8 bit times of 330 cycles, counted from 1 at each clock rate
	task automatic t_rates();
		int k;
		for (k = 0; k < 4; k++) begin
			bus(1'b1, `UB_OFF_MODE, {31'h0, k[0]});
			bus(1'b1, `UB_OFF_BAUD, {28'h0, k[1], 3'h1});
			fork
				ub_node_model_inst.send_byte(8'h55);
				begin
					repeat (1500) @(posedge mclk);
					chk(32'({hold_idle, measure}), 32'h3);
				end
			join
			repeat (6) @(posedge mclk);
			chk(32'({rx_flag, measure}), 32'h2);
			bus(1'b0, `UB_OFF_BAUD, 32'h0);
			chk(32'(rd[0]), 32'h0);
			bus(1'b0, `UB_OFF_DIV, 32'h0);
			chk(rd, {16'h0, div_exp[k]});
			if (k == 0) begin
				chk(32'(rd[15:8]), 32'h0);
			end
			bus(1'b0, `UB_OFF_RX, 32'h0);
			chk(32'(rx_flag), 32'h0);
		end
		$display("measurement rates done");
	endtask

	// break, then a nonzero character, each with wake armed
	task automatic t_wake();
		int i;
		for (i = 0; i < 2; i++) begin
			bus(1'b1, `UB_OFF_BAUD, 32'h2);
			fork
				if (i == 0) begin
					ub_node_model_inst.send_break(13);
				end else begin
					ub_node_model_inst.send_byte(8'h55);
				end
				begin
					repeat (8) @(posedge mclk);
					chk(32'({rx_flag, hold_idle}), 32'h3);
				end
			join
			bus(1'b0, `UB_OFF_BAUD, 32'h0);
			chk(32'(rd[1]), 32'h0);
			bus(1'b0, `UB_OFF_RX, 32'h0);
		end
		bus(1'b1, `UB_OFF_MODE, 32'h1);
		bus(1'b1, `UB_OFF_BAUD, 32'hb);
		fork
			ub_node_model_inst.send_break(13);
			begin
				repeat (1000) @(posedge mclk);
				chk(32'(measure), 32'h0);
			end
		join
		ub_node_model_inst.send_byte(8'h55);
		repeat (6) @(posedge mclk);
		bus(1'b0, `UB_OFF_DIV, 32'h0);
		chk(rd, 32'd83);
		bus(1'b0, `UB_OFF_RX, 32'h0);
		bus(1'b1, `UB_OFF_MODE, 32'h2);
		bus(1'b1, `UB_OFF_BAUD, 32'h2);
		bus(1'b0, `UB_OFF_BAUD, 32'h0);
		chk(32'(rd[1]), 32'h0);
		bus(1'b1, `UB_OFF_MODE, 32'h1);
		$display("wake on break done");
	endtask

	task automatic t_abort();
		bus(1'b1, `UB_OFF_BAUD, 32'h9);
		fork
			ub_node_model_inst.send_byte(8'h55);
			begin
				repeat (1000) @(posedge mclk);
				chk(32'(measure), 32'h1);
				bus(1'b1, `UB_OFF_BAUD, 32'h8);
				@(posedge mclk);
				chk(32'(measure), 32'h0);
				bus(1'b1, `UB_OFF_BAUD, 32'h88);
				bus(1'b0, `UB_OFF_BAUD, 32'h0);
				chk(32'(rd[7]), 32'h0);
			end
		join
		repeat (6) @(posedge mclk);
		chk(32'(rx_flag), 32'h0);
		$display("abort done");
	endtask

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// whole run is about 32k cycles
	initial begin
		repeat (90000) @(posedge mclk);
		err_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_freeze();
		t_rates();
		t_wake();
		t_abort();
		end_of_test();
	end
endmodule
